//--- design/sacc_clkdiv.sv
// Converter clock divider: one-cycle enable pulse per converter clock period
`timescale 1ns/1ps
`default_nettype none
module sacc_clkdiv
   import sacc_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // Control
   input  wire logic       run,
   input  wire logic [2:0] div_code,
   // Enable out
   output logic            tick
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [5:0] cnt;   // Cycles into current period
   } sacc_div_s;

   sacc_div_s  st_r;   // State register
   sacc_div_s  st_nxt; // Next state
   logic [5:0] period; // Decoded period

   // Decode divider code to period length
   always_comb begin
      unique case (div_code)
         3'h0: period = DIV_C0;
         3'h1: period = DIV_C1;
         3'h2: period = DIV_C2;
         3'h3: period = DIV_C3;
         3'h4: period = DIV_C4;
         3'h5: period = DIV_C5;
         3'h6: period = DIV_C6;
         3'h7: period = DIV_C7;
      endcase
   end

   // Count while running, restart when stopped
   always_comb begin
      st_nxt = st_r;
      tick   = 1'b0;
      if (!run) begin
         st_nxt.cnt = 6'h00;
      end else if (st_r.cnt >= period - 6'h01) begin
         st_nxt.cnt = 6'h00;
         tick       = 1'b1; // RULE11
      end else begin
         st_nxt.cnt = st_r.cnt + 6'h01;
      end
   end

   // Register state
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule
`default_nettype wire

//--- design/sacc_pkg.sv
// Package: register map, field layout, reset values, timing and carrier types for the ADC control
package sacc_pkg;

   // Register byte addresses (the printed offsets are not all multiples of four, so index*4)
   localparam logic [7:0]  IDX_CTRL_EXT   = 8'h8F;
   localparam logic [7:0]  IDX_CTRL       = 8'h93;
   localparam logic [7:0]  IDX_TIMING     = 8'h94;
   localparam logic [7:0]  IDX_PIN_CFG    = 8'h95;
   localparam logic [7:0]  IDX_RES_LOW    = 8'h96;
   localparam logic [7:0]  IDX_RES_HIGH   = 8'h97;
   localparam logic [9:0]  ADDR_CTRL_EXT  = {IDX_CTRL_EXT, 2'b00};
   localparam logic [9:0]  ADDR_CTRL      = {IDX_CTRL, 2'b00};
   localparam logic [9:0]  ADDR_TIMING    = {IDX_TIMING, 2'b00};
   localparam logic [9:0]  ADDR_PIN_CFG   = {IDX_PIN_CFG, 2'b00};
   localparam logic [9:0]  ADDR_RES_LOW   = {IDX_RES_LOW, 2'b00};
   localparam logic [9:0]  ADDR_RES_HIGH  = {IDX_RES_HIGH, 2'b00};
   // Byte address of the power mode register
   localparam logic [9:0]  ADDR_POWER     = 10'h280;

   // Control register field positions
   localparam int          CTRL_ENABLE_BIT = 7;
   localparam int          CTRL_FLAG_BIT   = 6;
   localparam int          CTRL_CMP_BIT    = 5;
   localparam int          CTRL_REF_BIT    = 4;
   localparam int          CTRL_ROUTE_LSB  = 1;
   localparam int          CTRL_GO_BIT     = 0;
   localparam int          EXT_INTREF_BIT  = 7;
   localparam int          TIM_DIV_LSB     = 5;
   localparam int          PIN_CFG_LSB     = 1;
   localparam int          POWER_IDLE_BIT  = 0;
   localparam int          POWER_DOWN_BIT  = 1;

   // Reset values
   localparam logic [7:0]  RST_REG8       = 8'h00;
   localparam logic [9:0]  RST_RESULT     = 10'h000;

   // Conversion timing in converter clock periods
   localparam logic [4:0]  CONV_BITS_TAD  = 5'h0C;
   localparam logic [4:0]  SAMPLE_MIN_TAD = 5'h02;
   localparam logic [4:0]  SAMPLE_MAX_TAD = 5'h0F;

   // Converter clock divider: system clocks per converter clock for each code
   localparam logic [5:0]  DIV_C0 = 6'h02;
   localparam logic [5:0]  DIV_C1 = 6'h04;
   localparam logic [5:0]  DIV_C2 = 6'h06;
   localparam logic [5:0]  DIV_C3 = 6'h08;
   localparam logic [5:0]  DIV_C4 = 6'h0C;
   localparam logic [5:0]  DIV_C5 = 6'h10;
   localparam logic [5:0]  DIV_C6 = 6'h18;
   localparam logic [5:0]  DIV_C7 = 6'h20;

   // Sequencer states
   typedef enum logic [1:0] {
      SQ_IDLE   = 2'b00,
      SQ_SAMPLE = 2'b01,
      SQ_CONV   = 2'b10
   } sacc_seq_e;

   // Analog core request bundle
   typedef struct packed {
      logic       powered;     // Analog core powered
      logic       ref_ext;     // Reference from external pin
      logic       intref_sel;  // Measure internal 1.03V reference
      logic [2:0] route;       // External channel code, 0 = none
      logic [6:0] pin_analog;  // Pins 7..1 set to analog
      logic       sample;      // Track/hold in sample phase
      logic       convert;     // Bit cycling phase
   } sacc_core_ctl_s;

endpackage

//--- design/sacc_top.sv
// SAR ADC control and digital compare with APB register access
// Overview of operation
// RULE1 - Writing go starts; normal done clears go
// RULE2 - Done loads result and sets flag
// RULE3 - Clearing go mid-conversion aborts it
// RULE4 - Compare sets flag only when input exceeds threshold
// RULE5 - Compare repeats while go set, never self-clears
// RULE6 - Flag set by hardware, cleared by software
// RULE7 - Enable bit gates conversion and compare
// RULE8 - Reference bit picks supply or external pin
// RULE9 - Route code 0 none, 1-7 channel
// RULE10 - Internal reference bit overrides external route
// RULE11 - Divider code sets converter clock period
// RULE12 - Sample time field plus one, clamped 2..15
// RULE13 - Conversion is 12 periods plus sample
// RULE14 - Result high holds 9:2, low 1:0
// RULE15 - Result pair is compare threshold
// RULE16 - Pin config bits make pins analog
// RULE17 - Runs in idle, disabled in power-down
// RULE18 - Software keeps converter period at least 1us
// RULE19 - Software conversion sequence
// RULE20 - Software compare sequence
// RULE21 - Result loads only on normal completion
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sacc_top
   import sacc_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Analog core
   output sacc_core_ctl_s   core_ctl,
   input  wire logic [9:0]  core_data,
   // Interrupt request and wake
   output logic             conv_irq
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic       module_enable;        // Converter enabled
      logic       conv_done_flag;       // Sticky event flag
      logic       compare_enable;       // Compare mode
      logic       reference_source_sel; // External reference
      logic [2:0] input_route_sel;      // Channel code
      logic       go;                   // Start/status
      logic       internal_ref_route;   // Internal 1.03V channel
      logic [2:0] conv_clock_div;       // Divider code
      logic [3:0] sample_time_sel;      // Sample field
      logic [6:0] pin_analog_select;    // Pin config
      logic [9:0] result;               // Result / threshold
      logic       idle_mode;            // CPU in idle
      logic       power_down;           // CPU in power-down
      sacc_seq_e  seq;                  // Sequencer state
      logic [4:0] tad_cnt;              // Converter periods in phase
      logic [31:0] rdata;               // Registered read data
      logic       err;                  // Registered error
   } sacc_state_s;

   sacc_state_s st_r;      // State register
   sacc_state_s st_nxt;    // Next state
   logic        tick;      // Converter clock enable
   logic        active;    // Converter may run
   logic        wr_en;     // APB write strobe
   logic        rd_en;     // APB read strobe
   logic [4:0]  sample_len; // Clamped sample time
   logic [7:0]  wb;        // Write byte

   ////////////////////////////////////////////////////////////////////////////
   // Converter clock divider
   sacc_clkdiv u_div (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .run      (st_r.seq != SQ_IDLE),
      .div_code (st_r.conv_clock_div),
      .tick     (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus strobes; zero wait states
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && !penable && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = st_r.err;
   assign prdata  = st_r.rdata;
   assign wb      = pwdata[7:0];

   // Enabled and not in power-down; idle keeps it running
   assign active = st_r.module_enable && !st_r.power_down; // RULE7 RULE17

   // Sample time field plus one, clamped
   always_comb begin
      sample_len = {1'b0, st_r.sample_time_sel} + 5'h01; // RULE12
      if (sample_len < SAMPLE_MIN_TAD) begin
         sample_len = SAMPLE_MIN_TAD; // RULE12
      end else if (sample_len > SAMPLE_MAX_TAD) begin
         sample_len = SAMPLE_MAX_TAD; // RULE12
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic: registers, then sequencer (hardware sets win)
   always_comb begin
      st_nxt = st_r;
      // Read data captured in setup phase, shown in access phase
      if (rd_en) begin
         st_nxt.err = 1'b0;
         unique case (paddr[9:0])
            ADDR_CTRL_EXT: st_nxt.rdata = {24'h0, st_r.internal_ref_route, 7'h00};
            ADDR_CTRL:     st_nxt.rdata = {24'h0, st_r.module_enable, st_r.conv_done_flag,
                                           st_r.compare_enable, st_r.reference_source_sel,
                                           st_r.input_route_sel, st_r.go};
            ADDR_TIMING:   st_nxt.rdata = {24'h0, st_r.conv_clock_div, 1'b0,
                                           st_r.sample_time_sel};
            ADDR_PIN_CFG:  st_nxt.rdata = {24'h0, st_r.pin_analog_select, 1'b0};
            ADDR_RES_LOW:  st_nxt.rdata = {30'h0, st_r.result[1:0]}; // RULE14
            ADDR_RES_HIGH: st_nxt.rdata = {24'h0, st_r.result[9:2]}; // RULE14
            ADDR_POWER:    st_nxt.rdata = {30'h0, st_r.power_down, st_r.idle_mode};
            default: begin
               st_nxt.rdata = 32'h0000_0000;
               st_nxt.err   = 1'b1;
            end
         endcase
      end else if (psel && !penable && pwrite) begin
         st_nxt.err = !(paddr[9:0] inside {ADDR_CTRL_EXT, ADDR_CTRL, ADDR_TIMING,
                                           ADDR_PIN_CFG, ADDR_RES_LOW, ADDR_RES_HIGH,
                                           ADDR_POWER}) || (paddr[11:10] != 2'b00);
      end
      // Upper address bits set: refuse, and show zero data like any unmapped read
      if (psel && !penable && (paddr[11:10] != 2'b00)) begin
         st_nxt.err   = 1'b1;
         st_nxt.rdata = 32'h0000_0000;
      end

      // Register writes
      if (wr_en && !st_r.err) begin
         unique case (paddr[9:0])
            ADDR_CTRL_EXT: st_nxt.internal_ref_route = wb[EXT_INTREF_BIT];
            ADDR_CTRL: begin
               st_nxt.module_enable        = wb[CTRL_ENABLE_BIT];
               st_nxt.conv_done_flag       = wb[CTRL_FLAG_BIT]; // RULE6
               st_nxt.compare_enable       = wb[CTRL_CMP_BIT];
               st_nxt.reference_source_sel = wb[CTRL_REF_BIT];
               st_nxt.input_route_sel      = wb[CTRL_ROUTE_LSB +: 3];
               st_nxt.go                   = wb[CTRL_GO_BIT]; // RULE1 RULE3 RULE5
            end
            ADDR_TIMING: begin
               st_nxt.conv_clock_div  = wb[TIM_DIV_LSB +: 3];
               st_nxt.sample_time_sel = wb[3:0];
            end
            ADDR_PIN_CFG:  st_nxt.pin_analog_select = wb[PIN_CFG_LSB +: 7];
            ADDR_RES_LOW:  st_nxt.result[1:0] = wb[1:0]; // RULE14 RULE15
            ADDR_RES_HIGH: st_nxt.result[9:2] = wb; // RULE14 RULE15
            ADDR_POWER: begin
               st_nxt.idle_mode  = wb[POWER_IDLE_BIT];
               st_nxt.power_down = wb[POWER_DOWN_BIT];
            end
            default: st_nxt.go = st_nxt.go;
         endcase
      end

      // Sequencer
      unique case (st_r.seq)
         SQ_IDLE: begin
            st_nxt.tad_cnt = 5'h00;
            if (st_r.go && active) begin
               st_nxt.seq = SQ_SAMPLE;
            end
         end
         SQ_SAMPLE: begin
            if (!st_nxt.go || !active) begin
               st_nxt.seq = SQ_IDLE; // RULE3 RULE7
            end else if (tick) begin
               if (st_r.tad_cnt == sample_len - 5'h01) begin
                  st_nxt.tad_cnt = 5'h00;
                  st_nxt.seq     = SQ_CONV; // RULE13
               end else begin
                  st_nxt.tad_cnt = st_r.tad_cnt + 5'h01;
               end
            end
         end
         SQ_CONV: begin
            if (!st_nxt.go || !active) begin
               st_nxt.seq = SQ_IDLE; // RULE3 RULE21
            end else if (tick) begin
               if (st_r.tad_cnt == CONV_BITS_TAD - 5'h01) begin // RULE13
                  st_nxt.tad_cnt = 5'h00;
                  if (st_r.compare_enable) begin
                     // Compare mode: re-sample, keep go and result
                     st_nxt.seq = SQ_SAMPLE; // RULE5 RULE21
                     if (core_data > st_r.result) begin
                        st_nxt.conv_done_flag = 1'b1; // RULE4 RULE15 RULE6
                     end
                  end else begin
                     st_nxt.seq            = SQ_IDLE;
                     st_nxt.go             = 1'b0; // RULE1
                     st_nxt.result         = core_data; // RULE2 RULE21
                     st_nxt.conv_done_flag = 1'b1; // RULE2 RULE6
                  end
               end else begin
                  st_nxt.tad_cnt = st_r.tad_cnt + 5'h01;
               end
            end
         end
         default: st_nxt.seq = SQ_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_r        <= '0;
         st_r.result <= RST_RESULT;
         st_r.seq    <= SQ_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Analog core controls
   always_comb begin
      core_ctl.powered    = active; // RULE7 RULE17
      core_ctl.ref_ext    = st_r.reference_source_sel; // RULE8
      core_ctl.intref_sel = st_r.internal_ref_route; // RULE10
      // Route nothing when internal ref is chosen; channel 3 lost to reference pin
      if (st_r.internal_ref_route ||
          (st_r.reference_source_sel && st_r.input_route_sel == 3'h3)) begin
         core_ctl.route = 3'h0; // RULE10 RULE8
      end else begin
         core_ctl.route = st_r.input_route_sel; // RULE9
      end
      core_ctl.pin_analog = st_r.pin_analog_select; // RULE16
      core_ctl.sample     = st_r.seq == SQ_SAMPLE;
      core_ctl.convert    = st_r.seq == SQ_CONV;
   end

   // Flag drives interrupt and idle wake
   assign conv_irq = st_r.conv_done_flag; // RULE17

endmodule
`default_nettype wire

//--- verification/sacc_core_model.sv
// Analog core model: hands back the input level while the bits cycle
`timescale 1ns/1ps
`default_nettype none
module sacc_core_model
   import sacc_pkg::*;
#(
   parameter logic [9:0] INTREF_CODE = 10'h1A5  // Level of the internal reference
)
(
   // Clock
   input  wire logic           core_clk,
   // Core control and input level
   input  wire sacc_core_ctl_s ctl,
   input  wire logic [9:0]     level,
   // Converted value
   output logic [9:0]          data
);
   initial data = 10'h000;
   ////////////////////////////////////////////////////////////////////////////////
   // Valid only in the bit phase; toggles otherwise so a stale sample shows
   always @(posedge core_clk) begin
      if (ctl.convert)
         data <= ctl.intref_sel ? INTREF_CODE : level;
      else
         data <= ~data;
   end
endmodule
`default_nettype wire

//--- verification/sacc_top_asserts.sv
// Port-level checks for the ADC control block
`timescale 1ns/1ps
`default_nettype none
module sacc_top_asserts
   import sacc_pkg::*;
(
   // Clock and reset
   input  wire logic           core_clk,
   input  wire logic           rst_n,
   // APB
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [11:0]    paddr,
   input  wire logic [31:0]    pwdata,
   input  wire logic           pready,
   input  wire logic           pslverr,
   input  wire logic [31:0]    prdata,
   // Analog core and flag
   input  wire sacc_core_ctl_s core_ctl,
   input  wire logic [9:0]     core_data,
   input  wire logic           conv_irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Write accesses to control and pin registers
   logic ctrl_wr;
   logic pin_wr;
   assign ctrl_wr = psel && penable && pwrite && paddr == {2'b00, ADDR_CTRL};
   assign pin_wr  = psel && penable && pwrite && paddr == {2'b00, ADDR_PIN_CFG};
   ////////////////////////////////////////////////////////////////////////////////
   a_irq_cause: assert property ($rose(conv_irq) |-> $past(core_ctl.convert))
      else $error("flag rose outside a bit phase");
   a_flag_sw_clear: assert property ($fell(conv_irq) |-> $past(ctrl_wr))
      else $error("flag cleared without a write");
   a_off_idle: assert property (!core_ctl.powered |=> !(core_ctl.sample || core_ctl.convert))
      else $error("core active while unpowered");
   a_abort_stop: assert property (ctrl_wr && !pwdata[CTRL_GO_BIT]
      |=> !(core_ctl.sample || core_ctl.convert))
      else $error("conversion kept running after go cleared");
   a_intref_route: assert property (core_ctl.intref_sel |-> core_ctl.route == 3'h0)
      else $error("external route open with internal reference");
   a_vref_pin: assert property (core_ctl.ref_ext |-> core_ctl.route != 3'h3)
      else $error("channel 3 routed while pin is reference");
   a_sample_min: assert property ($rose(core_ctl.sample) |-> core_ctl.sample [*4])
      else $error("sample phase shorter than two periods");
   a_sample_conv: assert property ($fell(core_ctl.sample) && !$past(ctrl_wr)
      |-> core_ctl.convert)
      else $error("bit phase did not follow sample");
   a_pin_follow: assert property (pin_wr |=> core_ctl.pin_analog == $past(pwdata[7:1]))
      else $error("pin select does not follow register");
   a_unmapped_err: assert property (psel && penable && paddr[11:10] != 2'h0 |-> pslverr)
      else $error("unmapped access not refused");
endmodule
bind sacc_top sacc_top_asserts u_sacc_top_asserts (.core_clk, .rst_n, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .core_ctl, .core_data, .conv_irq);
`default_nettype wire

//--- verification/sacc_top_bench.sv
// Self-checking bench for the ADC control block
`timescale 1ns/1ps
`default_nettype none
module sacc_top_bench import sacc_pkg::*; ;
   // Register addresses and implemented bits
   localparam logic [11:0] A_EXT = {2'b00, ADDR_CTRL_EXT};
   localparam logic [11:0] A_CTRL = {2'b00, ADDR_CTRL};
   localparam logic [11:0] A_TIM = {2'b00, ADDR_TIMING};
   localparam logic [11:0] A_LOW = {2'b00, ADDR_RES_LOW};
   localparam logic [11:0] A_HIGH = {2'b00, ADDR_RES_HIGH};
   localparam logic [11:0] A_PIN = {2'b00, ADDR_PIN_CFG};
   localparam logic [11:0] ADDRS [6] = '{A_EXT, A_CTRL, A_TIM, A_PIN, A_LOW, A_HIGH};
   localparam logic [7:0]  MASKS [6] = '{8'h80, 8'hFF, 8'hEF, 8'hFE, 8'h03, 8'hFF};
   localparam int          TAD [8] = '{DIV_C0, DIV_C1, DIV_C2, DIV_C3, DIV_C4, DIV_C5,
                                       DIV_C6, DIV_C7};
   localparam logic [9:0]  IREF = 10'h2C6;  // Arbitrary internal reference level
   // Design signals
   logic           core_clk, rst_n, psel, penable, pwrite, pready, pslverr, conv_irq;
   logic [11:0]    paddr;
   logic [31:0]    pwdata, prdata;
   logic [9:0]     level, core_data;
   sacc_core_ctl_s core_ctl;
   // Bench state and expected read notes
   int             errors = 0, n_compared = 0, cycles = 0;
   logic [15:0]    rnd = 16'hD682;
   typedef struct { string nm; logic [7:0] d; logic e; } sacc_note_s;
   sacc_note_s     notes [$];

   sacc_top u_sacc_top (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .pslverr, .prdata, .core_ctl, .core_data, .conv_irq);
   sacc_core_model #(.INTREF_CODE(IREF)) u_sacc_core_model (.core_clk, .ctl(core_ctl),
      .level, .data(core_data));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock at 25 MHz
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // APB transfer: setup, access held until pready, then release
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] d, input logic e);
      notes.push_back('{nm, d, e});
      apb(1'b0, a, 8'h00);
   endtask
   // Cycles from the last write's access edge until the flag is seen
   task automatic wait_irq(input int lim, output int n);
      n = 1;
      @(negedge core_clk);
      while (conv_irq !== 1'b1 && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Read monitor takes the oldest note; cycle ceiling cuts a hang short
   always @(posedge core_clk) begin
      if (psel && penable && !pwrite && pready === 1'b1 && notes.size() > 0) begin
         check(notes[0].nm, {24'h000000, notes[0].d}, prdata);
         check({notes[0].nm, " error"}, {31'h0, notes[0].e}, {31'h0, pslverr});
         void'(notes.pop_front());
      end
      cycles++;
      if (cycles == 40000) begin
         errors++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int n, ex, s;
      logic [3:0] ts;
      logic [9:0] lv, th;
      logic [7:0] cw, d;
      logic [2:0] c;
      {rst_n, psel, penable, pwrite, paddr, pwdata, level} = '0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      // Reset values and read-back, then a refused access
      foreach (ADDRS[i]) begin
         rnd = lfsr(rnd);
         d = (i == 1) ? 8'h00 : rnd[7:0];
         rd("reset value", ADDRS[i], 8'h00, 1'b0);
         apb(1'b1, ADDRS[i], d);
         rd("read back", ADDRS[i], d & MASKS[i], 1'b0);
      end
      rd("unmapped", 12'hC00, 8'h00, 1'b1);
      // Random read-back may have left the internal reference selected
      apb(1'b1, A_EXT, 8'h00);
      $display("test registers done");
      // Every divider code; boundary sample fields at the slowest clocks
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         ts = (i == 6) ? 4'h0 : (i == 7) ? 4'hF : rnd[3:0];
         s = (ts == 4'h0) ? 2 : (ts == 4'hF) ? 15 : ts + 1;
         ex = (CONV_BITS_TAD + s) * TAD[i];
         lv = rnd[15:6];
         level <= lv;
         cw = {4'h8, rnd[2:0], 1'b1};
         apb(1'b1, A_TIM, {i[2:0], 1'b0, ts});
         apb(1'b1, A_CTRL, cw);
         wait_irq(1200, n);
         check("conversion time", 32'h1, n >= ex && n <= ex + 3);
         rd("result high", A_HIGH, lv[9:2], 1'b0);
         rd("result low", A_LOW, {6'h00, lv[1:0]}, 1'b0);
         rd("control after done", A_CTRL, (cw & 8'hFE) | 8'h40, 1'b0);
         apb(1'b1, A_CTRL, 8'h80);
      end
      $display("test conversion done");
      // Abort in mid-conversion keeps the old result and raises nothing
      apb(1'b1, A_TIM, 8'h00);
      level <= ~lv;
      apb(1'b1, A_CTRL, 8'h83);
      repeat (12) @(posedge core_clk);
      apb(1'b1, A_CTRL, 8'h80);
      wait_irq(100, n);
      check("flag after abort", 32'h0, conv_irq);
      rd("result after abort", A_HIGH, lv[9:2], 1'b0);
      $display("test abort done");
      // Compare: equal input never hits, one above does; go and threshold stay
      th = {1'b0, rnd[8:0]};
      apb(1'b1, A_HIGH, th[9:2]);
      apb(1'b1, A_LOW, {6'h00, th[1:0]});
      level <= th;
      apb(1'b1, A_CTRL, 8'hA3);
      wait_irq(200, n);
      check("flag at equal input", 32'h0, conv_irq);
      level <= th + 10'h001;
      wait_irq(200, n);
      check("flag above threshold", 32'h1, conv_irq);
      rd("control in compare", A_CTRL, 8'hE3, 1'b0);
      rd("threshold kept", A_LOW, {6'h00, th[1:0]}, 1'b0);
      apb(1'b1, A_CTRL, 8'h80);
      $display("test compare done");
      // Idle keeps converting; power-down and a cleared enable stop it
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, {2'b00, ADDR_POWER}, (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : 8'h00);
         apb(1'b1, A_CTRL, (i == 2) ? 8'h03 : 8'h83);
         wait_irq(100, n);
         check("flag in power mode", i == 0, conv_irq);
         apb(1'b1, A_CTRL, 8'h00);
      end
      $display("test power done");
      // Pin select, route codes, reference pin and internal reference override
      rnd = lfsr(rnd);
      apb(1'b1, A_PIN, rnd[7:0]);
      check("pin select", rnd[7:1], core_ctl.pin_analog);
      for (int i = 0; i < 10; i++) begin
         c = (i < 8) ? i[2:0] : (i == 8) ? 3'h3 : 3'h5;
         apb(1'b1, A_EXT, (i == 9) ? 8'h80 : 8'h00);
         apb(1'b1, A_CTRL, {3'h4, i == 8, c, 1'b0});
         check("route", (i < 8) ? c : 3'h0, core_ctl.route);
         check("external reference", i == 8, core_ctl.ref_ext);
         check("internal reference", i == 9, core_ctl.intref_sel);
      end
      // Slowest divider keeps the converter period above one microsecond
      apb(1'b1, A_TIM, 8'hE0);
      apb(1'b1, A_CTRL, 8'h8B);
      wait_irq(600, n);
      rd("internal reference result", A_HIGH, IREF[9:2], 1'b0);
      $display("test routing done");
      final_report();
   end
endmodule
`default_nettype wire
